// ### bench/access_master.sv
// Bus master model that presents memory accesses to the monitor.
`timescale 1ns/1ns
module access_master (
   input  wire logic         MCLK,
   input  wire logic         REQ_VALID,
   input  wire logic [116:0] REQ_FIELDS,
   output logic              ACC_VALID,
   output logic [31:0]       ACC_ADDR,
   output logic [63:0]       ACC_WDATA,
   output logic              ACC_WRITE,
   output logic              ACC_DOUBLE,
   output logic [2:0]        ACC_CHANNEL,
   output logic [15:0]       ACC_INITIATOR
);
   initial
   begin
      ACC_VALID = 1'b0;
      {ACC_ADDR, ACC_WDATA, ACC_WRITE, ACC_DOUBLE, ACC_CHANNEL, ACC_INITIATOR} = 117'h0;
   end
   // Idle fields flip every cycle, so a stale access can never pass for a fresh one.
   always @(posedge MCLK)
   begin
      ACC_VALID <= REQ_VALID;
      {ACC_ADDR, ACC_WDATA, ACC_WRITE, ACC_DOUBLE, ACC_CHANNEL, ACC_INITIATOR} <= REQ_VALID ? REQ_FIELDS :
         ~{ACC_ADDR, ACC_WDATA, ACC_WRITE, ACC_DOUBLE, ACC_CHANNEL, ACC_INITIATOR};
   end
endmodule // access_master

// ### bench/tb.sv
// Self-checking bench for the access-watch monitor.
`timescale 1ns/1ns
module tb;
   logic         mclk;
   logic         arst_n;
   logic [7:0]   reg_addr;
   logic [31:0]  reg_wdata;
   logic         reg_wr;
   logic         reg_rd;
   logic [31:0]  reg_rdata;
   logic         req_valid;
   logic [116:0] req_fields;
   logic         acc_valid;
   logic [31:0]  acc_addr;
   logic [63:0]  acc_wdata;
   logic         acc_write;
   logic         acc_double;
   logic [2:0]   acc_channel;
   logic [15:0]  acc_initiator;
   logic         watch_irq;
   int           errors;
   int           total_checks;
   int           cycles;
   logic [31:0]  cfg [7];
   logic [31:0]  stat [4];
   logic [3:0]   pipe;
   logic         armed;

   memory_access_watch_monitor u_dut (.MCLK(mclk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr),
      .ACC_WDATA(acc_wdata), .ACC_WRITE(acc_write), .ACC_DOUBLE(acc_double), .ACC_CHANNEL(acc_channel),
      .ACC_INITIATOR(acc_initiator), .WATCH_IRQ(watch_irq));
   access_master u_bus (.MCLK(mclk), .REQ_VALID(req_valid), .REQ_FIELDS(req_fields), .ACC_VALID(acc_valid),
      .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata), .ACC_WRITE(acc_write), .ACC_DOUBLE(acc_double),
      .ACC_CHANNEL(acc_channel), .ACC_INITIATOR(acc_initiator));

   task automatic conclude();
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      chk(reg_rdata, exp);
   endtask

   function automatic logic [31:0] wmask(int k);
      return (k < 4) ? 32'hFFFF_FFFF : (k == 4) ? 32'h000F_FFFF : (k == 5) ? 32'h0000_0003 : 32'h0000_001F;
   endfunction

   // Compared data half, chosen by the low-word select for double words.
   function automatic logic [31:0] half(logic [63:0] wd, logic dbl);
      return (dbl && !cfg[5][1]) ? wd[63:32] : wd[31:0];
   endfunction

   function automatic logic hit(logic [31:0] ad, logic [31:0] d, logic w, logic [2:0] ch, logic [15:0] id);
      logic m;
      m = (!cfg[6][3] || ch == cfg[4][18:16]) && (!cfg[6][2] || id == cfg[4][15:0]);
      return (!cfg[6][4] || w == cfg[5][0]) && (!cfg[6][1] || (w && ((d ^ cfg[2]) & ~cfg[3]) == 32'h0))
         && (!cfg[6][0] || ((ad ^ cfg[0]) & ~cfg[1]) == 32'h0) && (!(cfg[6][3] || cfg[6][2]) || m == cfg[4][19]);
   endfunction

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end

   initial
   begin
      logic [31:0] ad;
      logic [31:0] m;
      logic [63:0] wd;
      logic        w;
      logic        dbl;
      logic        h;
      logic [2:0]  ch;
      logic [15:0] id;
      {arst_n, reg_addr, reg_wdata, reg_wr, reg_rd, req_valid, req_fields} = '0;
      {errors, total_checks, cycles} = '0;
      stat = '{default: 32'h0};
      void'($urandom(65));
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      for (int k = 0; k < 12; k++)
         rc(8'hD0 + 8'(4 * k), 32'h0);
      rc(8'h10, 32'h0);
      for (int r = 0; r < 40; r++)
      begin
         // Writing the control word is always allowed, so a round that saw no hit still disarms here.
         wr(8'hEC, 32'h0);
         for (int k = 0; k < 7; k++)
         begin
            cfg[k] = $urandom() & wmask(k);
            wr(8'hD0 + 8'(4 * k), cfg[k]);
         end
         for (int k = 0; k < 7; k++)
            rc(8'hD0 + 8'(4 * k), cfg[k]);
         wr(8'hEC, 32'h1);
         wr(8'hD0, ~cfg[0]);
         wr(8'hE8, ~cfg[6]);
         wr(8'hF0, 32'hFFFF_FFFF);
         rc(8'hD0, cfg[0]);
         rc(8'hE8, cfg[6]);
         armed = 1'b1;
         pipe = 4'h0;
         for (int i = 0; i < 20; i++)
         begin
            @(posedge mclk);
            chk(32'(watch_irq), 32'(pipe[2]));
            ad = $urandom();
            wd = {$urandom(), $urandom()};
            {w, dbl, ch, id} = 21'($urandom());
            if ($urandom() & 1)
            begin
               ad = cfg[0] ^ (ad & cfg[1]);
               m = cfg[2] ^ (wd[31:0] & cfg[3]);
               wd = ($urandom() & 1) ? {wd[63:32], m} : {m, wd[31:0]};
               {ch, id, w} = {cfg[4][18:0], cfg[5][0]};
            end
            h = (i < 17) && armed && hit(ad, half(wd, dbl), w, ch, id);
            if (h)
            begin
               armed = 1'b0;
               stat = '{ad, half(wd, dbl), {13'h0, ch, id}, {31'h0, w}};
            end
            pipe = {pipe[2:0], h};
            req_valid <= (i < 17);
            req_fields <= {ad, wd, w, dbl, ch, id};
         end
         rc(8'hEC, {31'h0, armed});
         for (int k = 0; k < 4; k++)
            rc(8'hF0 + 8'(4 * k), stat[k]);
      end
      conclude();
   end
endmodule // tb

// ### design/memory_access_watch_monitor.sv
// Access-watch monitor comparing bus master accesses with a programmed pattern.
`timescale 1ns/1ns
module memory_access_watch_monitor #(
   parameter int CH_W = 3,
   parameter int ID_W = 16
) (
   input  wire logic              MCLK,
   input  wire logic              ARST_N,
   input  wire logic [7:0]        REG_ADDR,
   input  wire logic [31:0]       REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output logic      [31:0]       REG_RDATA,
   input  wire logic              ACC_VALID,
   input  wire logic [31:0]       ACC_ADDR,
   input  wire logic [63:0]       ACC_WDATA,
   input  wire logic              ACC_WRITE,
   input  wire logic              ACC_DOUBLE,
   input  wire logic [CH_W-1:0]   ACC_CHANNEL,
   input  wire logic [ID_W-1:0]   ACC_INITIATOR,
   output logic                   WATCH_IRQ
);
   logic [31:0]     base_address;
   logic [31:0]     address_qualifier;
   logic [31:0]     data_value;
   logic [31:0]     data_qualifier;
   logic            match_polarity;
   logic [CH_W-1:0] watched_channel;
   logic [ID_W-1:0] watched_initiator;
   logic            low_word_sel;
   logic            direction_sel;
   logic            direction_check_on;
   logic            channel_check_on;
   logic            initiator_check_on;
   logic            data_check_on;
   logic            address_check_on;
   logic            armed;
   logic [31:0]     st_address;
   logic [31:0]     st_data;
   logic [CH_W-1:0] st_channel;
   logic [ID_W-1:0] st_initiator;
   logic            st_write;
   logic            setup_wr;
   logic [31:0]     compared_data;
   logic            addr_ok;
   logic            data_ok;
   logic            dir_ok;
   logic            master_ok;
   logic            hit;

   function automatic logic masked_equal(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
      masked_equal = ((a ^ b) & ~m) == 32'h0000_0000;
   endfunction

   // Setup writes are dropped while armed so a live watch cannot be altered mid-run.
   assign setup_wr = REG_WR && !armed; // [RULE10]

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         base_address      <= watch_pkg::RST_WORD;
         address_qualifier <= watch_pkg::RST_WORD;
         data_value        <= watch_pkg::RST_WORD;
         data_qualifier    <= watch_pkg::RST_WORD;
      end
      else if (setup_wr)
      begin
         case (REG_ADDR)
            watch_pkg::OFS_BASE:       base_address      <= REG_WDATA; // [RULE1]
            watch_pkg::OFS_ADDR_QUAL:  address_qualifier <= REG_WDATA; // [RULE2]
            watch_pkg::OFS_DATA_VALUE: data_value        <= REG_WDATA; // [RULE3]
            watch_pkg::OFS_DATA_QUAL:  data_qualifier    <= REG_WDATA; // [RULE4]
            default:                   ;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         match_polarity     <= watch_pkg::RST_MASTER[watch_pkg::POS_POLARITY];
         watched_channel    <= CH_W'(watch_pkg::RST_MASTER >> watch_pkg::POS_CH_LO);
         watched_initiator  <= ID_W'(watch_pkg::RST_MASTER);
         low_word_sel       <= watch_pkg::RST_ACCESS[watch_pkg::POS_LOW_SEL];
         direction_sel      <= watch_pkg::RST_ACCESS[watch_pkg::POS_DIR_SEL];
         direction_check_on <= watch_pkg::RST_POLICY[watch_pkg::POS_EN_DIR];
         channel_check_on   <= watch_pkg::RST_POLICY[watch_pkg::POS_EN_CH];
         initiator_check_on <= watch_pkg::RST_POLICY[watch_pkg::POS_EN_ID];
         data_check_on      <= watch_pkg::RST_POLICY[watch_pkg::POS_EN_DATA];
         address_check_on   <= watch_pkg::RST_POLICY[watch_pkg::POS_EN_ADDR];
      end
      else if (setup_wr)
      begin
         case (REG_ADDR)
            watch_pkg::OFS_MASTER:
            begin
               match_polarity    <= REG_WDATA[watch_pkg::POS_POLARITY];                    // [RULE5]
               watched_channel   <= REG_WDATA[watch_pkg::POS_CH_LO +: CH_W];               // [RULE6]
               watched_initiator <= REG_WDATA[watch_pkg::POS_ID_LO +: ID_W];               // [RULE7]
            end
            watch_pkg::OFS_ACCESS:
            begin
               low_word_sel  <= REG_WDATA[watch_pkg::POS_LOW_SEL]; // [RULE8]
               direction_sel <= REG_WDATA[watch_pkg::POS_DIR_SEL]; // [RULE9]
            end
            watch_pkg::OFS_POLICY:
            begin
               direction_check_on <= REG_WDATA[watch_pkg::POS_EN_DIR];  // [RULE11]
               channel_check_on   <= REG_WDATA[watch_pkg::POS_EN_CH];
               initiator_check_on <= REG_WDATA[watch_pkg::POS_EN_ID];
               data_check_on      <= REG_WDATA[watch_pkg::POS_EN_DATA];
               address_check_on   <= REG_WDATA[watch_pkg::POS_EN_ADDR];
            end
            default: ;
         endcase
      end
   end

   // Single-word writes always use the low lane; the select only matters for double words.
   assign compared_data = (ACC_DOUBLE && !low_word_sel) ? ACC_WDATA[63:32] : ACC_WDATA[31:0]; // [RULE8]

   assign addr_ok   = !address_check_on || masked_equal(ACC_ADDR, base_address, address_qualifier); // [RULE14]
   assign data_ok   = !data_check_on || (ACC_WRITE && masked_equal(compared_data, data_value, data_qualifier));
   assign dir_ok    = !direction_check_on || (ACC_WRITE == direction_sel); // [RULE9]
   // With neither master check enabled the master criterion is neutral regardless of polarity.
   assign master_ok = !(channel_check_on || initiator_check_on) ||
                      (((!channel_check_on || ACC_CHANNEL == watched_channel) &&
                        (!initiator_check_on || ACC_INITIATOR == watched_initiator)) == match_polarity); // [RULE5]
   assign hit = armed && ACC_VALID && addr_ok && data_ok && dir_ok && master_ok; // [RULE14]

   // A hit wins over a software write of the arm bit in the same cycle.
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         armed <= 1'b0;
      else if (hit)
         armed <= 1'b0; // [RULE12]
      else if (REG_WR && REG_ADDR == watch_pkg::OFS_CONTROL)
         armed <= REG_WDATA[watch_pkg::POS_ARM];
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         WATCH_IRQ <= 1'b0;
      else
         WATCH_IRQ <= hit;
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         st_address   <= watch_pkg::RST_WORD;
         st_data      <= watch_pkg::RST_WORD;
         st_channel   <= '0;
         st_initiator <= '0;
         st_write     <= 1'b0;
      end
      else if (hit)
      begin
         st_address   <= ACC_ADDR;      // [RULE13]
         st_data      <= compared_data;
         st_channel   <= ACC_CHANNEL;
         st_initiator <= ACC_INITIATOR;
         st_write     <= ACC_WRITE;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         REG_RDATA <= 32'h0000_0000;
      else if (REG_RD)
      begin
         case (REG_ADDR)
            watch_pkg::OFS_BASE:       REG_RDATA <= base_address;
            watch_pkg::OFS_ADDR_QUAL:  REG_RDATA <= address_qualifier;
            watch_pkg::OFS_DATA_VALUE: REG_RDATA <= data_value;
            watch_pkg::OFS_DATA_QUAL:  REG_RDATA <= data_qualifier;
            watch_pkg::OFS_MASTER:     REG_RDATA <= 32'((32'(match_polarity) << watch_pkg::POS_POLARITY)
                                                 | (32'(watched_channel) << watch_pkg::POS_CH_LO)
                                                 | 32'(watched_initiator));
            watch_pkg::OFS_ACCESS:     REG_RDATA <= {30'h0000_0000, low_word_sel, direction_sel};
            watch_pkg::OFS_POLICY:     REG_RDATA <= {27'h000_0000, direction_check_on, channel_check_on,
                                                     initiator_check_on, data_check_on, address_check_on};
            watch_pkg::OFS_CONTROL:    REG_RDATA <= {31'h0000_0000, armed};
            watch_pkg::OFS_ST_ADDR:    REG_RDATA <= st_address;   // [RULE13]
            watch_pkg::OFS_ST_DATA:    REG_RDATA <= st_data;
            watch_pkg::OFS_ST_MASTER:  REG_RDATA <= 32'((32'(st_channel) << watch_pkg::POS_CH_LO) | 32'(st_initiator));
            watch_pkg::OFS_ST_ACCESS:  REG_RDATA <= {31'h0000_0000, st_write};
            default:                   REG_RDATA <= 32'h0000_0000;
         endcase
      end
      else
         REG_RDATA <= 32'h0000_0000;
   end

   property p_locked_base;
      @(posedge MCLK) disable iff (!ARST_N)
      armed |=> $stable(base_address);
   endproperty
   a_locked_base: assert property (p_locked_base) else $error("Base address changed while armed."); // [RULE10]

   property p_base_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && !armed && REG_ADDR == watch_pkg::OFS_BASE) |=> base_address == $past(REG_WDATA);
   endproperty
   a_base_write: assert property (p_base_write) else $error("Base address write lost."); // [RULE1]

   property p_disarm;
      @(posedge MCLK) disable iff (!ARST_N)
      hit |=> !armed && WATCH_IRQ;
   endproperty
   a_disarm: assert property (p_disarm) else $error("Arm bit not cleared after interrupt."); // [RULE12]

   property p_capture;
      @(posedge MCLK) disable iff (!ARST_N)
      hit |=> st_address == $past(ACC_ADDR) && st_write == $past(ACC_WRITE);
   endproperty
   a_capture: assert property (p_capture) else $error("Triggering access not captured."); // [RULE13]

   property p_irq_cause;
      @(posedge MCLK) disable iff (!ARST_N)
      WATCH_IRQ |-> $past(armed) && $past(ACC_VALID);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("Interrupt without an armed access."); // [RULE14]

   property p_direction;
      @(posedge MCLK) disable iff (!ARST_N)
      (hit && direction_check_on) |-> ACC_WRITE == direction_sel;
   endproperty
   a_direction: assert property (p_direction) else $error("Hit on wrong direction."); // [RULE9]

   property p_address;
      @(posedge MCLK) disable iff (!ARST_N)
      (hit && address_check_on) |-> ((ACC_ADDR ^ base_address) & ~address_qualifier) == 32'h0000_0000;
   endproperty
   a_address: assert property (p_address) else $error("Hit with address mismatch."); // [RULE2]

   property p_master;
      @(posedge MCLK) disable iff (!ARST_N)
      (hit && channel_check_on && !initiator_check_on) |-> (ACC_CHANNEL == watched_channel) == match_polarity;
   endproperty
   a_master: assert property (p_master) else $error("Hit with wrong master polarity."); // [RULE5]

   property p_read_data;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_RD && REG_ADDR == watch_pkg::OFS_CONTROL) |=> REG_RDATA == {31'h0000_0000, $past(armed)};
   endproperty
   a_read_data: assert property (p_read_data) else $error("Control read returned wrong value."); // [RULE12]

   property p_locked_words;
      @(posedge MCLK) disable iff (!ARST_N)
      armed |=> $stable(address_qualifier) && $stable(data_value) && $stable(data_qualifier);
   endproperty
   a_locked_words: assert property (p_locked_words) else $error("Setup word changed while armed."); // [RULE10]

   property p_locked_fields;
      @(posedge MCLK) disable iff (!ARST_N)
      armed |=> $stable({match_polarity, watched_channel, watched_initiator, low_word_sel, direction_sel});
   endproperty
   a_locked_fields: assert property (p_locked_fields) else $error("Master setup changed while armed."); // [RULE10]

   property p_locked_policy;
      @(posedge MCLK) disable iff (!ARST_N)
      armed |=> $stable({direction_check_on, channel_check_on, initiator_check_on, data_check_on, address_check_on});
   endproperty
   a_locked_policy: assert property (p_locked_policy) else $error("Policy changed while armed."); // [RULE10]

   property p_qualifier_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && !armed && REG_ADDR == watch_pkg::OFS_ADDR_QUAL) |=> address_qualifier == $past(REG_WDATA);
   endproperty
   a_qualifier_write: assert property (p_qualifier_write) else $error("Address mask write lost."); // [RULE2]

   property p_value_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && !armed && REG_ADDR == watch_pkg::OFS_DATA_VALUE) |=> data_value == $past(REG_WDATA);
   endproperty
   a_value_write: assert property (p_value_write) else $error("Compare value write lost."); // [RULE3]

   property p_data_mask_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && !armed && REG_ADDR == watch_pkg::OFS_DATA_QUAL) |=> data_qualifier == $past(REG_WDATA);
   endproperty
   a_data_mask_write: assert property (p_data_mask_write) else $error("Data mask write lost."); // [RULE4]

   property p_channel_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && !armed && REG_ADDR == watch_pkg::OFS_MASTER) |=>
         watched_channel == CH_W'($past(REG_WDATA) >> watch_pkg::POS_CH_LO);
   endproperty
   a_channel_write: assert property (p_channel_write) else $error("Watched channel write lost."); // [RULE6]

   property p_initiator_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && !armed && REG_ADDR == watch_pkg::OFS_MASTER) |=>
         watched_initiator == ID_W'($past(REG_WDATA) >> watch_pkg::POS_ID_LO) &&
         match_polarity == 1'($past(REG_WDATA) >> watch_pkg::POS_POLARITY);
   endproperty
   a_initiator_write: assert property (p_initiator_write) else $error("Watched initiator write lost."); // [RULE7]

   property p_policy_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && !armed && REG_ADDR == watch_pkg::OFS_POLICY) |=>
         {direction_check_on, channel_check_on, initiator_check_on, data_check_on, address_check_on} ==
         5'($past(REG_WDATA) >> watch_pkg::POS_EN_ADDR);
   endproperty
   a_policy_write: assert property (p_policy_write) else $error("Policy enable write lost."); // [RULE11]

   property p_arm_write;
      @(posedge MCLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == watch_pkg::OFS_CONTROL && !hit) |=>
         armed == 1'($past(REG_WDATA) >> watch_pkg::POS_ARM);
   endproperty
   a_arm_write: assert property (p_arm_write) else $error("Arm bit write lost."); // [RULE10]

   property p_irq_pulse;
      @(posedge MCLK) disable iff (!ARST_N)
      WATCH_IRQ |=> !WATCH_IRQ;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("Interrupt longer than one cycle."); // [RULE12]

   property p_data;
      @(posedge MCLK) disable iff (!ARST_N)
      (hit && data_check_on) |-> ACC_WRITE && ((compared_data ^ data_value) & ~data_qualifier) == 32'h0000_0000;
   endproperty
   a_data: assert property (p_data) else $error("Hit with write data mismatch."); // [RULE4]

   property p_lane_low;
      @(posedge MCLK) disable iff (!ARST_N)
      (hit && (!ACC_DOUBLE || low_word_sel)) |=> st_data == 32'($past(ACC_WDATA));
   endproperty
   a_lane_low: assert property (p_lane_low) else $error("Low data half not captured."); // [RULE8]

   property p_lane_high;
      @(posedge MCLK) disable iff (!ARST_N)
      (hit && ACC_DOUBLE && !low_word_sel) |=> st_data == 32'($past(ACC_WDATA) >> 32);
   endproperty
   a_lane_high: assert property (p_lane_high) else $error("High data half not captured."); // [RULE8]

   property p_other_master;
      @(posedge MCLK) disable iff (!ARST_N)
      (hit && (channel_check_on || initiator_check_on) && !match_polarity) |->
         !((!channel_check_on || ACC_CHANNEL == watched_channel) &&
           (!initiator_check_on || ACC_INITIATOR == watched_initiator));
   endproperty
   a_other_master: assert property (p_other_master) else $error("Hit on watched master at polarity 0."); // [RULE5]
endmodule // memory_access_watch_monitor

// ### design/watch_pkg.sv
// Package with register map, field layout and reset values of the access-watch monitor.
// Summary of operation
// RULE1: Software-writable 32-bit base address compared against monitored accesses.
// RULE2: 32-bit address mask selects which address bits are compared.
// RULE3: 32-bit compare value matched against monitored write data.
// RULE4: 32-bit data mask selects which write-data bits are compared.
// RULE5: Polarity bit 1 triggers on watched master, 0 on any other master.
// RULE6: 3-bit watched channel number used in master comparison.
// RULE7: 16-bit watched initiator ID used in master comparison.
// RULE8: Double-word writes compare low half when select is 1, high half when 0.
// RULE9: Direction bit 0 watches reads only, 1 watches writes only.
// RULE10: While armed, all setup registers ignore software writes.
// RULE11: Five enables choose direction, channel, initiator, data and address criteria.
// RULE12: Arm bit clears itself once the watch interrupt is raised.
// RULE13: Triggering access address, data, channel, ID and type are captured read-only.
// RULE14: Interrupt only when every enabled criterion matches; set mask bit excludes bit.
package watch_pkg;
   localparam logic [7:0]  OFS_BASE        = 8'hD0;
   localparam logic [7:0]  OFS_ADDR_QUAL   = 8'hD4;
   localparam logic [7:0]  OFS_DATA_VALUE  = 8'hD8;
   localparam logic [7:0]  OFS_DATA_QUAL   = 8'hDC;
   localparam logic [7:0]  OFS_MASTER      = 8'hE0;
   localparam logic [7:0]  OFS_ACCESS      = 8'hE4;
   localparam logic [7:0]  OFS_POLICY      = 8'hE8;
   localparam logic [7:0]  OFS_CONTROL     = 8'hEC;
   localparam logic [7:0]  OFS_ST_ADDR     = 8'hF0;
   localparam logic [7:0]  OFS_ST_DATA     = 8'hF4;
   localparam logic [7:0]  OFS_ST_MASTER   = 8'hF8;
   localparam logic [7:0]  OFS_ST_ACCESS   = 8'hFC;
   localparam int          POS_POLARITY    = 19;
   localparam int          POS_CH_LO       = 16;
   localparam int          POS_ID_LO       = 0;
   localparam int          POS_LOW_SEL     = 1;
   localparam int          POS_DIR_SEL     = 0;
   localparam int          POS_EN_DIR      = 4;
   localparam int          POS_EN_CH       = 3;
   localparam int          POS_EN_ID       = 2;
   localparam int          POS_EN_DATA     = 1;
   localparam int          POS_EN_ADDR     = 0;
   localparam int          POS_ARM         = 0;
   localparam logic [31:0] RST_WORD        = 32'h0000_0000;
   localparam logic [19:0] RST_MASTER      = 20'h0_0000;
   localparam logic [1:0]  RST_ACCESS      = 2'h0;
   localparam logic [4:0]  RST_POLICY      = 5'h00;
endpackage
